// ### bscs_consts.vh
`ifndef BSCS_CONSTS_VH
`define BSCS_CONSTS_VH

// ----------------------------------------------------------------
// Line timing
// ----------------------------------------------------------------
`define BSCS_CLK_HZ       10000000
`define BSCS_BAUD         19200
`define BSCS_BAUD_DIV     ((`BSCS_CLK_HZ + `BSCS_BAUD / 2) / `BSCS_BAUD)
`define BSCS_TURN_MS      5
// Least time, exact at this clock rate (50000 cycles)
`define BSCS_TURN_CYC     ((`BSCS_CLK_HZ / 1000) * `BSCS_TURN_MS)

// ----------------------------------------------------------------
// Packet framing
// ----------------------------------------------------------------
`define BSCS_LEAD_232     8'hca
`define BSCS_LEAD_485     8'hcc
`define BSCS_ADDR_HI      8'h00
`define BSCS_ADDR_232     8'h01
`define BSCS_ADDR_MIN     8'h01
`define BSCS_ADDR_MAX     8'h64
`define BSCS_MAX_DATA     4'h8
`define BSCS_CS_INV       8'hff

// ----------------------------------------------------------------
// Error reply
// ----------------------------------------------------------------
`define BSCS_ERR_CMD      8'h0f
`define BSCS_ERR_LEN      4'h2
`define BSCS_ERR_UNKNOWN  8'h01
`define BSCS_ERR_CHECKSUM 8'h02

`endif

// ### bscs_uart.v
`timescale 1ns/100ps
module bscs_uart
#(
	parameter DIV = 521
)
(
	// Clock and reset
	input  wire       clk_i,
	input  wire       rst_n_i,
	input  wire       clr_i,
	// Receive side
	input  wire       rx_i,
	output reg        rx_valid_o,
	output reg        rx_ferr_o,
	output reg  [7:0] rx_byte_o,
	// Transmit side
	input  wire       tx_start_i,
	input  wire [7:0] tx_byte_i,
	output reg        tx_done_o,
	output reg        tx_o
);

localparam [15:0] DLIM = DIV - 1;
localparam [15:0] HALF = DIV / 2;

reg        rx_busy;
reg [15:0] rx_cnt;
reg  [3:0] rx_bit;
reg  [7:0] rx_sh;
reg        tx_busy;
reg [15:0] tx_cnt;
reg  [3:0] tx_bit;
reg  [8:0] tx_sh;

// ----------------------------------------------------------------
// Receiver, 8N1, sampled mid-bit
// ----------------------------------------------------------------
always @(posedge clk_i or negedge rst_n_i)
begin
	if (!rst_n_i)
	begin
		rx_busy    <= 1'b0;
		rx_cnt     <= 16'h0000;
		rx_bit     <= 4'h0;
		rx_sh      <= 8'h00;
		rx_valid_o <= 1'b0;
		rx_ferr_o  <= 1'b0;
		rx_byte_o  <= 8'h00;
	end
	else
	begin
		rx_valid_o <= 1'b0;
		rx_ferr_o  <= 1'b0;
		if (clr_i)
			rx_busy <= 1'b0;
		else if (!rx_busy)
		begin
			if (!rx_i)
			begin
				rx_busy <= 1'b1;
				rx_cnt  <= HALF;
				rx_bit  <= 4'h0;
			end
		end
		else if (rx_cnt != 16'h0000)
			rx_cnt <= rx_cnt - 16'h0001;
		else
		begin
			rx_cnt <= DLIM;
			if (rx_bit == 4'h0)
			begin
				// A start glitch shorter than half a bit is dropped
				if (rx_i)
					rx_busy <= 1'b0;
				else
					rx_bit <= 4'h1;
			end
			else if (rx_bit == 4'h9)
			begin
				rx_busy <= 1'b0;
				if (rx_i)
				begin
					rx_valid_o <= 1'b1;
					rx_byte_o  <= rx_sh;
				end
				else
					rx_ferr_o <= 1'b1;
			end
			else
			begin
				rx_sh  <= {rx_i, rx_sh[7:1]};
				rx_bit <= rx_bit + 4'h1;
			end
		end
	end
end

// ----------------------------------------------------------------
// Transmitter, LSB first
// ----------------------------------------------------------------
always @(posedge clk_i or negedge rst_n_i)
begin
	if (!rst_n_i)
	begin
		tx_busy   <= 1'b0;
		tx_cnt    <= 16'h0000;
		tx_bit    <= 4'h0;
		tx_sh     <= 9'h1ff;
		tx_done_o <= 1'b0;
		tx_o      <= 1'b1;
	end
	else
	begin
		tx_done_o <= 1'b0;
		if (clr_i)
		begin
			tx_busy <= 1'b0;
			tx_o    <= 1'b1;
		end
		else if (!tx_busy)
		begin
			if (tx_start_i)
			begin
				tx_busy <= 1'b1;
				tx_o    <= 1'b0;
				tx_sh   <= {1'b1, tx_byte_i};
				tx_cnt  <= DLIM;
				tx_bit  <= 4'h0;
			end
		end
		else if (tx_cnt != 16'h0000)
			tx_cnt <= tx_cnt - 16'h0001;
		else if (tx_bit == 4'h9)
		begin
			tx_busy   <= 1'b0;
			tx_done_o <= 1'b1;
		end
		else
		begin
			tx_o   <= tx_sh[0];
			tx_sh  <= {1'b1, tx_sh[8:1]};
			tx_bit <= tx_bit + 4'h1;
			tx_cnt <= DLIM;
		end
	end
end

endmodule

// ### bscs_slave.v
`timescale 1ns/100ps
`include "bscs_consts.vh"
module bscs_slave
#(
	parameter BAUD_DIV = `BSCS_BAUD_DIV,
	parameter TURN_CYC = `BSCS_TURN_CYC,
	parameter TW       = 24
)
(
	// Clock and reset
	input  wire        clk_i,
	input  wire        rst_n_i,
	// Front panel and strapping
	input  wire        comm_en_i,
	input  wire        rs485_i,
	input  wire  [6:0] station_addr_i,
	// Serial line
	input  wire        rx_i,
	output wire        tx_o,
	output wire        tx_en_o,
	// Command to the controller
	output reg         req_valid_o,
	output reg   [7:0] req_cmd_o,
	output reg   [3:0] req_len_o,
	output reg  [63:0] req_data_o,
	// Answer from the controller
	input  wire        rsp_valid_i,
	input  wire        rsp_known_i,
	input  wire  [3:0] rsp_len_i,
	input  wire [63:0] rsp_data_i
);

localparam [3:0] S_HUNT  = 4'h0;
localparam [3:0] S_ADDRH = 4'h1;
localparam [3:0] S_ADDRL = 4'h2;
localparam [3:0] S_CMD   = 4'h3;
localparam [3:0] S_CNT   = 4'h4;
localparam [3:0] S_DATA  = 4'h5;
localparam [3:0] S_CSUM  = 4'h6;
localparam [3:0] S_APP   = 4'h7;
localparam [3:0] S_SEND  = 4'h8;
localparam [TW-1:0] TURN_LIM = TURN_CYC;

reg     [3:0] state;
reg     [7:0] lead;
reg     [7:0] addr_lo;
reg           addr_ok;
reg     [3:0] didx;
reg     [7:0] sum;
reg    [63:0] rx_data;
reg     [7:0] r_cmd;
reg     [3:0] r_len;
reg    [63:0] r_data;
reg     [3:0] tidx;
reg     [7:0] tsum;
reg           inflight;
reg  [TW-1:0] turn_cnt;
reg     [7:0] tx_byte;
wire          rx_valid;
wire          rx_ferr;
wire    [7:0] rx_byte;
wire          tx_done;
wire          tx_start;
wire          parsing;
wire          turn_ok;
wire    [3:0] last_idx;
wire    [3:0] dsel;
wire    [7:0] lead_want;
wire          addr_match;

// ----------------------------------------------------------------
// Byte framing
// ----------------------------------------------------------------
// 8N1 at 19200
bscs_uart #(.DIV(BAUD_DIV)) u_uart
(
	.clk_i      (clk_i),
	.rst_n_i    (rst_n_i),
	.clr_i      (!comm_en_i),
	.rx_i       (rx_i),
	.rx_valid_o (rx_valid),
	.rx_ferr_o  (rx_ferr),
	.rx_byte_o  (rx_byte),
	.tx_start_i (tx_start),
	.tx_byte_i  (tx_byte),
	.tx_done_o  (tx_done),
	.tx_o       (tx_o)
);

assign parsing    = (state != S_APP) && (state != S_SEND);
// Lead byte follows the interface type
assign lead_want  = rs485_i ? `BSCS_LEAD_485 : `BSCS_LEAD_232;
// Station address in range and matched on RS-485; fixed address 01 on RS-232
assign addr_match = rs485_i ? ((rx_byte == {1'b0, station_addr_i}) &&
                               ({1'b0, station_addr_i} >= `BSCS_ADDR_MIN) &&
                               ({1'b0, station_addr_i} <= `BSCS_ADDR_MAX))
                            : (rx_byte == `BSCS_ADDR_232);
// Hold off the driver for the turnaround time
assign turn_ok    = !rs485_i || (turn_cnt == TURN_LIM);
assign last_idx   = r_len + 4'h5;
assign dsel       = tidx - 4'h5;
assign tx_start   = (state == S_SEND) && !inflight && turn_ok;
// Driver drops the cycle after the last stop bit ends
assign tx_en_o    = (state == S_SEND) && rs485_i && turn_ok;

// ----------------------------------------------------------------
// Received data bytes, one lane per data position
// ----------------------------------------------------------------
genvar k;
generate
	for (k = 0; k < 8; k = k + 1)
	begin : g_lane
		always @(posedge clk_i or negedge rst_n_i)
		begin
			if (!rst_n_i)
				rx_data[8*k +: 8] <= 8'h00;
			else if (rx_valid && parsing && (state == S_DATA) && (didx == k))
				rx_data[8*k +: 8] <= rx_byte;
		end
	end
endgenerate

// ----------------------------------------------------------------
// Reply byte selection
// ----------------------------------------------------------------
// Echo header, then count, data and fresh checksum
always @*
begin
	tx_byte = 8'h00;
	case (tidx)
		4'h0: tx_byte = lead;
		4'h1: tx_byte = `BSCS_ADDR_HI;
		4'h2: tx_byte = addr_lo;
		4'h3: tx_byte = r_cmd;
		4'h4: tx_byte = {4'h0, r_len};
		default:
		begin
			if (tidx == last_idx)
				tx_byte = tsum ^ `BSCS_CS_INV;
			else
				tx_byte = r_data[{dsel[2:0], 3'b000} +: 8];
		end
	endcase
end

// ----------------------------------------------------------------
// Turnaround counter, restarted on every checksum byte
// ----------------------------------------------------------------
always @(posedge clk_i or negedge rst_n_i)
begin
	if (!rst_n_i)
		turn_cnt <= {TW{1'b0}};
	else if (rx_valid && parsing && (state == S_CSUM))
		turn_cnt <= {TW{1'b0}};
	else if (turn_cnt != TURN_LIM)
		turn_cnt <= turn_cnt + {{(TW-1){1'b0}}, 1'b1};
end

// ----------------------------------------------------------------
// Packet parser and reply sequencer
// ----------------------------------------------------------------
always @(posedge clk_i or negedge rst_n_i)
begin
	if (!rst_n_i)
	begin
		state       <= S_HUNT;
		lead        <= 8'h00;
		addr_lo     <= 8'h00;
		addr_ok     <= 1'b0;
		didx        <= 4'h0;
		sum         <= 8'h00;
		r_cmd       <= 8'h00;
		r_len       <= 4'h0;
		r_data      <= 64'h0;
		tidx        <= 4'h0;
		tsum        <= 8'h00;
		inflight    <= 1'b0;
		req_valid_o <= 1'b0;
		req_cmd_o   <= 8'h00;
		req_len_o   <= 4'h0;
		req_data_o  <= 64'h0;
	end
	// Disabled link is idle and silent
	else if (!comm_en_i)
	begin
		state       <= S_HUNT;
		inflight    <= 1'b0;
		req_valid_o <= 1'b0;
	end
	else if (rx_ferr && parsing)
		state <= S_HUNT;
	else
	begin
		case (state)
			S_HUNT:
			begin
				// Lead compared as a raw byte
				if (rx_valid && (rx_byte == lead_want))
				begin
					lead  <= rx_byte;
					state <= S_ADDRH;
				end
			end
			S_ADDRH:
			begin
				if (rx_valid)
				begin
					sum     <= rx_byte;
					addr_ok <= (rx_byte == `BSCS_ADDR_HI);
					state   <= S_ADDRL;
				end
			end
			S_ADDRL:
			begin
				if (rx_valid)
				begin
					sum     <= sum + rx_byte;
					addr_lo <= rx_byte;
					addr_ok <= addr_ok && addr_match;
					state   <= S_CMD;
				end
			end
			S_CMD:
			begin
				if (rx_valid)
				begin
					sum       <= sum + rx_byte;
					req_cmd_o <= rx_byte;
					state     <= S_CNT;
				end
			end
			S_CNT:
			begin
				if (rx_valid)
				begin
					sum       <= sum + rx_byte;
					req_len_o <= rx_byte[3:0];
					didx      <= 4'h0;
					// Count above 8 cannot be framed
					if (rx_byte > {4'h0, `BSCS_MAX_DATA})
						state <= S_HUNT;
					else if (rx_byte == 8'h00)
						state <= S_CSUM;
					else
						state <= S_DATA;
				end
			end
			S_DATA:
			begin
				if (rx_valid)
				begin
					sum  <= sum + rx_byte;
					didx <= didx + 4'h1;
					if (didx + 4'h1 == req_len_o)
						state <= S_CSUM;
				end
			end
			S_CSUM:
			begin
				if (rx_valid)
				begin
					tidx     <= 4'h0;
					tsum     <= 8'h00;
					inflight <= 1'b0;
					if (!addr_ok)
						state <= S_HUNT;
					else if (rx_byte == (sum ^ `BSCS_CS_INV))
					begin
						req_data_o  <= rx_data;
						req_valid_o <= 1'b1;
						state       <= S_APP;
					end
					else
					begin
						r_cmd  <= `BSCS_ERR_CMD;
						r_len  <= `BSCS_ERR_LEN;
						r_data <= {48'h0, `BSCS_ERR_CHECKSUM, req_cmd_o};
						state  <= S_SEND;
					end
				end
			end
			S_APP:
			begin
				if (rsp_valid_i)
				begin
					req_valid_o <= 1'b0;
					state       <= S_SEND;
					if (rsp_known_i)
					begin
						r_cmd  <= req_cmd_o;
						r_len  <= (rsp_len_i > `BSCS_MAX_DATA) ? `BSCS_MAX_DATA : rsp_len_i;
						r_data <= rsp_data_i;
					end
					else
					begin
						r_cmd  <= `BSCS_ERR_CMD;
						r_len  <= `BSCS_ERR_LEN;
						r_data <= {48'h0, `BSCS_ERR_UNKNOWN, req_cmd_o};
					end
				end
			end
			S_SEND:
			begin
				// One packet, then back to listening
				if (tx_start)
				begin
					inflight <= 1'b1;
					if ((tidx != 4'h0) && (tidx != last_idx))
						tsum <= tsum + tx_byte;
				end
				if (tx_done)
				begin
					inflight <= 1'b0;
					tidx     <= tidx + 4'h1;
					if (tidx == last_idx)
						state <= S_HUNT;
				end
			end
			default: state <= S_HUNT;
		endcase
	end
end

endmodule

// ### bscs_props.sv
`timescale 1ns/100ps
module bscs_props
#(
	parameter BAUD_DIV = 8,
	parameter TURN_CYC = 200
)
(
	// Clock and reset
	input wire       clk_i,
	input wire       rst_n_i,
	// Watched ports
	input wire       comm_en_i,
	input wire       rs485_i,
	input wire       tx_o,
	input wire       tx_en_o,
	input wire       req_valid_o,
	input wire [7:0] req_cmd_o,
	input wire       rsp_valid_i
);
	reg [23:0] since_req;
	reg [23:0] hi_run;
	// Saturated after reset so an early error reply cannot look premature
	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			since_req <= 24'hffffff;
			hi_run    <= 24'h0;
		end
		else
		begin
			if ($rose(req_valid_o))
				since_req <= 24'h0;
			else if (since_req != 24'hffffff)
				since_req <= since_req + 24'h1;
			hi_run <= (tx_en_o && tx_o) ? hi_run + 24'h1 : 24'h0;
		end
	end
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);
	sequence start_bit_s;
		!tx_o [*4];
	endsequence
	sequence req_done_s;
		req_valid_o && rsp_valid_i;
	endsequence
	no_drive_a: assert property (!rs485_i |-> !tx_en_o)
		else $error("driver enabled on point-to-point link");
	off_quiet_a: assert property (!comm_en_i |=> tx_o && !req_valid_o)
		else $error("activity while link disabled");
	wait_quiet_a: assert property (req_valid_o |-> tx_o)
		else $error("sending before the answer is known");
	one_reply_a: assert property (req_done_s |=> !req_valid_o)
		else $error("request kept after answer");
	reply_start_a: assert property (req_done_s ##0 !rs485_i |=> ##1 $fell(tx_o))
		else $error("reply did not start");
	start_bit_a: assert property ($fell(tx_o) |-> start_bit_s)
		else $error("start bit too short");
	hold_req_a: assert property (req_valid_o && !rsp_valid_i && comm_en_i |=> req_valid_o && $stable(req_cmd_o))
		else $error("request changed while waiting");
	turn_wait_a: assert property ($rose(tx_en_o) |-> since_req >= TURN_CYC - 3)
		else $error("driver enabled too early");
	drive_low_a: assert property (rs485_i && !tx_o |-> tx_en_o)
		else $error("line low without driver");
	// A reply byte of all ones keeps the line high for nine bit times
	release_a: assert property (hi_run <= 9 * BAUD_DIV + 3)
		else $error("driver held after reply");
endmodule
bind bscs_slave bscs_props #(.BAUD_DIV(BAUD_DIV), .TURN_CYC(TURN_CYC)) bscs_props_inst (.clk_i(clk_i),
	.rst_n_i(rst_n_i), .comm_en_i(comm_en_i), .rs485_i(rs485_i), .tx_o(tx_o), .tx_en_o(tx_en_o),
	.req_valid_o(req_valid_o), .req_cmd_o(req_cmd_o), .rsp_valid_i(rsp_valid_i));

// ### bscs_host.sv
`timescale 1ns/100ps
module bscs_host
#(
	parameter DIV = 8
)
(
	input  wire clk_i,
	input  wire tx_i,
	output reg  line_o
);
	reg [7:0] rb [0:15];
	integer   rn;
	initial line_o = 1'b1;
	task send_byte(input [7:0] b, input stop_ok);
		reg [9:0] f;
		integer   i;
		begin
			f = {stop_ok, b, 1'b0};
			for (i = 0; i < 10; i = i + 1)
			begin
				line_o <= f[i];
				repeat (DIV) @(posedge clk_i);
			end
		end
	endtask
	task send_pkt(input [7:0] lead, input [7:0] addr, input [7:0] cmd, input [3:0] n, input [63:0] d,
		input [7:0] cs_flip, input integer bad_at);
		reg [7:0] p [0:14];
		reg [7:0] s;
		integer   i;
		begin
			p[0] = lead;
			p[1] = 8'h00;
			p[2] = addr;
			p[3] = cmd;
			p[4] = {4'h0, n};
			for (i = 0; i < n; i = i + 1)
				p[5 + i] = d[8 * (i % 8) +: 8];
			s = 8'h00;
			for (i = 1; i < 5 + n; i = i + 1)
				s = s + p[i];
			p[5 + n] = s ^ 8'hff ^ cs_flip;
			for (i = 0; i < 6 + n; i = i + 1)
				if (i <= bad_at)
					send_byte(p[i], i != bad_at);
			line_o <= 1'b1;
		end
	endtask
	task get_byte(input integer lim, output [7:0] b, output ok);
		integer i;
		begin
			ok = 1'b0;
			b = 8'h00;
			for (i = 0; i < lim && !ok; i = i + 1)
			begin
				@(posedge clk_i);
				ok = (tx_i === 1'b0);
			end
			if (ok)
			begin
				repeat (DIV / 2) @(posedge clk_i);
				for (i = 0; i < 8; i = i + 1)
				begin
					repeat (DIV) @(posedge clk_i);
					b[i] = tx_i;
				end
				repeat (DIV) @(posedge clk_i);
				ok = (tx_i === 1'b1);
			end
		end
	endtask
	task get_reply(input integer lim);
		reg [7:0] b;
		reg       ok;
		begin
			rn = 0;
			get_byte(lim, b, ok);
			while (ok && rn < 16)
			begin
				rb[rn] = b;
				rn = rn + 1;
				get_byte(4 * DIV, b, ok);
			end
		end
	endtask
endmodule

// ### tb_bath_serial_command_slave.sv
`timescale 1ns/100ps
module tb_bath_serial_command_slave;
	reg         clk_i = 1'b0;
	reg         rst_n_i = 1'b0;
	reg         comm_en_i;
	reg         rs485_i;
	reg  [6:0]  station_addr_i;
	reg         rsp_valid_i = 1'b0;
	reg         rsp_known_i = 1'b1;
	reg  [3:0]  rsp_len_i;
	reg  [63:0] rsp_data_i;
	wire        rx_i;
	wire        tx_o;
	wire        tx_en_o;
	wire        req_valid_o;
	wire [7:0]  req_cmd_o;
	wire [3:0]  req_len_o;
	wire [63:0] req_data_o;
	reg  [7:0]  seen_cmd;
	reg  [3:0]  seen_len;
	reg  [63:0] seen_data;
	integer     errors = 0;
	integer     checks = 0;
	// Released RS-485 pair is biased high
	wire        line = (rs485_i && tx_en_o !== 1'b1) ? 1'b1 : tx_o;
	always #50 clk_i = ~clk_i;
	bscs_slave #(.BAUD_DIV(8), .TURN_CYC(200)) bscs_slave_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.comm_en_i(comm_en_i), .rs485_i(rs485_i), .station_addr_i(station_addr_i), .rx_i(rx_i), .tx_o(tx_o),
		.tx_en_o(tx_en_o), .req_valid_o(req_valid_o), .req_cmd_o(req_cmd_o), .req_len_o(req_len_o),
		.req_data_o(req_data_o), .rsp_valid_i(rsp_valid_i), .rsp_known_i(rsp_known_i), .rsp_len_i(rsp_len_i),
		.rsp_data_i(rsp_data_i));
	bscs_host #(.DIV(8)) bscs_host_inst (.clk_i(clk_i), .tx_i(line), .line_o(rx_i));
	// Controller: command 55 is the only unknown one
	always @(posedge clk_i)
	begin
		rsp_valid_i <= 1'b0;
		if (req_valid_o === 1'b1 && rsp_valid_i !== 1'b1)
		begin
			seen_cmd <= req_cmd_o;
			seen_len <= req_len_o;
			seen_data <= req_data_o;
			rsp_known_i <= (req_cmd_o !== 8'h55);
			rsp_valid_i <= 1'b1;
		end
	end
	task chk(input [63:0] got, input [63:0] exp);
		begin
			checks = checks + 1;
			if (got !== exp)
			begin
				errors = errors + 1;
				$display("ERROR %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task xact(input [7:0] lead, input [7:0] addr, input [7:0] cmd, input [3:0] n, input [63:0] d,
		input [7:0] flip, input integer bad);
		begin
			bscs_host_inst.send_pkt(lead, addr, cmd, n, d, flip, bad);
			bscs_host_inst.get_reply(400);
		end
	endtask
	task chk_reply(input [7:0] lead, input [7:0] addr, input [7:0] cmd, input [3:0] n, input [63:0] d);
		reg [7:0] e [0:13];
		reg [7:0] s;
		integer   i;
		begin
			e[0] = lead;
			e[1] = 8'h00;
			e[2] = addr;
			e[3] = cmd;
			e[4] = {4'h0, n};
			s = 8'h00;
			for (i = 0; i < n; i = i + 1)
				e[5 + i] = d[8 * i +: 8];
			for (i = 1; i < 5 + n; i = i + 1)
				s = s + e[i];
			e[5 + n] = s ^ 8'hff;
			chk(bscs_host_inst.rn, 6 + n);
			for (i = 0; i < 6 + n; i = i + 1)
				chk(bscs_host_inst.rb[i], e[i]);
		end
	endtask
	task t_reads;
		begin
			xact(8'hca, 8'h01, 8'h20, 4'h0, 64'h0, 8'h00, 99);
			chk(seen_cmd, 8'h20);
			chk_reply(8'hca, 8'h01, 8'h20, 4'h3, 64'h332211);
			xact(8'hca, 8'h01, 8'hf0, 4'h8, 64'h0807060504030201, 8'h00, 99);
			chk(seen_len, 4'h8);
			chk(seen_data, 64'h0807060504030201);
			chk_reply(8'hca, 8'h01, 8'hf0, 4'h3, 64'h332211);
		end
	endtask
	task t_errors;
		begin
			xact(8'hca, 8'h01, 8'h20, 4'h0, 64'h0, 8'h01, 99);
			chk_reply(8'hca, 8'h01, 8'h0f, 4'h2, 64'h0220);
			xact(8'hca, 8'h01, 8'h55, 4'h0, 64'h0, 8'h00, 99);
			chk_reply(8'hca, 8'h01, 8'h0f, 4'h2, 64'h0155);
		end
	endtask
	task t_drops;
		begin
			xact(8'hca, 8'h01, 8'h20, 4'h9, 64'h1111111111111111, 8'h00, 99);
			chk(bscs_host_inst.rn, 0);
			xact(8'hca, 8'h01, 8'h20, 4'h0, 64'h0, 8'h00, 2);
			chk(bscs_host_inst.rn, 0);
			comm_en_i <= 1'b0;
			xact(8'hca, 8'h01, 8'h20, 4'h0, 64'h0, 8'h00, 99);
			chk(bscs_host_inst.rn, 0);
			comm_en_i <= 1'b1;
			xact(8'hca, 8'h01, 8'h21, 4'h0, 64'h0, 8'h00, 99);
			chk_reply(8'hca, 8'h01, 8'h21, 4'h3, 64'h332211);
		end
	endtask
	task t_rs485;
		begin
			rs485_i <= 1'b1;
			rst_n_i <= 1'b0;
			repeat (3) @(posedge clk_i);
			rst_n_i <= 1'b1;
			xact(8'hcc, 8'h06, 8'h20, 4'h0, 64'h0, 8'h00, 99);
			chk(bscs_host_inst.rn, 0);
			xact(8'hcc, 8'h05, 8'h70, 4'h0, 64'h0, 8'h00, 99);
			chk_reply(8'hcc, 8'h05, 8'h70, 4'h3, 64'h332211);
			station_addr_i <= 7'h65;
			xact(8'hcc, 8'h65, 8'h20, 4'h0, 64'h0, 8'h00, 99);
			chk(bscs_host_inst.rn, 0);
		end
	endtask
	task give_verdict;
		begin
			$display("Comparisons %0d, mismatches %0d", checks, errors);
			if (errors == 0 && checks > 0)
				$display("All checks passed");
			else
				$display("Checks failed");
			$finish;
		end
	endtask
	// About 13k cycles expected; allow 50k
	initial
	begin
		#5000000;
		errors = errors + 1;
		give_verdict;
	end
	initial
	begin
		comm_en_i = 1'b1;
		rs485_i = 1'b0;
		station_addr_i = 7'h05;
		rsp_len_i = 4'h3;
		rsp_data_i = 64'h332211;
		repeat (3) @(posedge clk_i);
		rst_n_i <= 1'b1;
		t_reads;
		t_errors;
		t_drops;
		t_rs485;
		give_verdict;
	end
endmodule
